/* agc_config_status_regs.sv */
// register slice of the gain control: left applied-gain report and right configuration
// assumes a same-clock register port from the control-bus front end and a same-clock left gain loop
`timescale 1ns/100ps
`default_nettype none
`include "agc_regs_defines.svh"
module agc_config_status_regs #(
    parameter int TIME_W = 24
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire agc_regs_pkg::reg_req_t   reg_req,
    output logic [7:0]                    reg_rdata,
    output logic                          reg_rvalid,
    input  wire logic signed [7:0]        left_gain_in,
    input  wire logic                     left_gain_upd,
    output agc_regs_pkg::level_cfg_t      right_cfg,
    output logic [TIME_W-1:0]             right_attack_periods,
    output logic [TIME_W-1:0]             right_decay_periods
);
    import agc_regs_pkg::*;

    // =====================================================================
    // storage
    logic signed [7:0] left_gain_q;
    logic [7:0]        ctl_first_q;
    logic [7:0]        ctl_second_q;
    logic [6:0]        ceiling_q;
    logic [7:0]        attack_q;
    logic [7:0]        decay_q;
    logic [7:0]        rdata_d;

    function automatic logic hit(input reg_req_t r, input logic [7:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction : hit

    // clamp to the reportable span so the status never shows a reserved code
    function automatic logic signed [7:0] clamp_gain(input logic signed [7:0] g);
        if (g < $signed(`GAIN_REPORT_MIN)) begin
            clamp_gain = $signed(`GAIN_REPORT_MIN);
        end else if (g > $signed(`GAIN_REPORT_MAX)) begin
            clamp_gain = $signed(`GAIN_REPORT_MAX);
        end else begin
            clamp_gain = g;
        end
    endfunction : clamp_gain

    // =====================================================================
    // left applied-gain status; bus writes never reach it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            left_gain_q <= `RST_LEFT_GAIN_NOW;
        end else if (left_gain_upd) begin
            left_gain_q <= clamp_gain(left_gain_in);
        end
    end

    // =====================================================================
    // right configuration registers; reserved bits are not stored
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctl_first_q <= `RST_RIGHT_CTL_FIRST;
        end else if (hit(reg_req, `OFS_RIGHT_CTL_FIRST)) begin
            ctl_first_q <= {reg_req.wdata[`BIT_ENABLE:`TARGET_LO], 4'h0};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctl_second_q <= `RST_RIGHT_CTL_SECOND;
        end else if (hit(reg_req, `OFS_RIGHT_CTL_SECOND)) begin
            ctl_second_q <= reg_req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ceiling_q <= `RST_RIGHT_CEILING;
        end else if (hit(reg_req, `OFS_RIGHT_CEILING)) begin
            ceiling_q <= reg_req.wdata[`CEIL_HI:`CEIL_LO];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            attack_q <= `RST_RIGHT_ATTACK;
        end else if (hit(reg_req, `OFS_RIGHT_ATTACK)) begin
            attack_q <= reg_req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            decay_q <= `RST_RIGHT_DECAY;
        end else if (hit(reg_req, `OFS_RIGHT_DECAY)) begin
            decay_q <= reg_req.wdata;
        end
    end

    // =====================================================================
    // read path; unmapped offsets read zero
    always_comb begin
        rdata_d = 8'h00;
        case (reg_req.addr)
            `OFS_LEFT_GAIN_NOW:    rdata_d = left_gain_q;
            `OFS_RIGHT_CTL_FIRST:  rdata_d = ctl_first_q;
            `OFS_RIGHT_CTL_SECOND: rdata_d = ctl_second_q;
            `OFS_RIGHT_CEILING:    rdata_d = {1'b0, ceiling_q};
            `OFS_RIGHT_ATTACK:     rdata_d = attack_q;
            `OFS_RIGHT_DECAY:      rdata_d = decay_q;
            default:               rdata_d = 8'h00;
        endcase
    end

    // read data shows the value before a same-cycle write
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata <= rdata_d;
            end
        end
    end

    // =====================================================================
    // decoded views for the right gain loop
    agc_level_decode u_level (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .ctl_first  (ctl_first_q),
        .ctl_second (ctl_second_q),
        .ceiling    (ceiling_q),
        .cfg        (right_cfg)
    );

    agc_time_scale #(
        .BASE_SHIFT (`ATTACK_BASE_SHIFT),
        .OUT_W      (TIME_W)
    ) u_attack (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .base_code (attack_q[`TIME_BASE_HI:`TIME_BASE_LO]),
        .mult_code (attack_q[`TIME_MULT_HI:`TIME_MULT_LO]),
        .periods   (right_attack_periods)
    );

    agc_time_scale #(
        .BASE_SHIFT (`DECAY_BASE_SHIFT),
        .OUT_W      (TIME_W)
    ) u_decay (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .base_code (decay_q[`TIME_BASE_HI:`TIME_BASE_LO]),
        .mult_code (decay_q[`TIME_MULT_HI:`TIME_MULT_LO]),
        .periods   (right_decay_periods)
    );
endmodule : agc_config_status_regs
`default_nettype wire

/* agc_regs_defines.svh */
// register offsets, field positions, reset values and codes of the gain-control register slice
// assumes it is included by bare name from every design file that needs these constants
`ifndef AGC_REGS_DEFINES_SVH
`define AGC_REGS_DEFINES_SVH

// =====================================================================
// register offsets
`define OFS_LEFT_GAIN_NOW    8'h5D
`define OFS_RIGHT_CTL_FIRST  8'h5E
`define OFS_RIGHT_CTL_SECOND 8'h5F
`define OFS_RIGHT_CEILING    8'h60
`define OFS_RIGHT_ATTACK     8'h61
`define OFS_RIGHT_DECAY      8'h62

// =====================================================================
// reset values
`define RST_LEFT_GAIN_NOW    8'h00
`define RST_RIGHT_CTL_FIRST  8'h00
`define RST_RIGHT_CTL_SECOND 8'h00
`define RST_RIGHT_CEILING    7'h7F
`define RST_RIGHT_ATTACK     8'h00
`define RST_RIGHT_DECAY      8'h00

// =====================================================================
// field positions
`define BIT_ENABLE           7
`define TARGET_HI            6
`define TARGET_LO            4
`define HYST_HI              7
`define HYST_LO              6
`define NOISE_HI             5
`define NOISE_LO             1
`define BIT_CLIP_STEP        0
`define CEIL_HI              6
`define CEIL_LO              0
`define TIME_BASE_HI         7
`define TIME_BASE_LO         3
`define TIME_MULT_HI         2
`define TIME_MULT_LO         0

// =====================================================================
// codes, limits in half-dB units, and time base shifts
`define GAIN_REPORT_MIN      8'hE8
`define GAIN_REPORT_MAX      8'h50
`define CEIL_CODE_MAX        7'h50
`define HYST_CODE_OFF        2'h3
`define NOISE_CODE_OFF       5'h00
`define ATTACK_BASE_SHIFT    5
`define DECAY_BASE_SHIFT     9

`endif

/* agc_regs_pkg.sv */
// types shared by the gain-control register slice and its helpers
// assumes agc_regs_defines.svh is reachable on the include path
package agc_regs_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic              enable;
        logic              clip_step;
        logic              hyst_on;
        logic              noise_on;
        logic signed [7:0] target_hdb;
        logic        [3:0] hyst_hdb;
        logic signed [8:0] noise_hdb;
        logic        [6:0] ceiling_hdb;
    } level_cfg_t;

endpackage : agc_regs_pkg

/* agc_time_scale.sv */
// turns a base-code and multiplier pair into a count of sample periods
// assumes the codes come from registers on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "agc_regs_defines.svh"
module agc_time_scale #(
    parameter int BASE_SHIFT = 5,
    parameter int OUT_W      = 24
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [4:0]       base_code,
    input  wire logic [2:0]       mult_code,
    output logic      [OUT_W-1:0] periods
);
    import agc_regs_pkg::*;

    // =====================================================================
    // (2N+1) * 2^BASE_SHIFT * 2^M
    function automatic logic [OUT_W-1:0] scale(input logic [4:0] n, input logic [2:0] m);
        logic [OUT_W-1:0] odd;
        odd   = OUT_W'({n, 1'b1});
        scale = odd << (BASE_SHIFT + int'(m));
    endfunction : scale

    // registered so the long shift stays off downstream paths
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            periods <= '0;
        end else begin
            periods <= scale(base_code, mult_code);
        end
    end
endmodule : agc_time_scale
`default_nettype wire

/* agc_level_decode.sv */
// decodes the right level fields into half-dB figures for the gain loop
// assumes the field codes come from registers on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "agc_regs_defines.svh"
module agc_level_decode (
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire logic [7:0]              ctl_first,
    input  wire logic [7:0]              ctl_second,
    input  wire logic [6:0]              ceiling,
    output agc_regs_pkg::level_cfg_t     cfg
);
    import agc_regs_pkg::*;

    // =====================================================================
    // target level; code 000 is ambiguous, taken as -5.5 dB
    function automatic logic signed [7:0] target_hdb(input logic [2:0] c);
        case (c)
            3'h0:    target_hdb = -8'sd11;
            3'h1:    target_hdb = -8'sd20;
            3'h2:    target_hdb = -8'sd24;
            3'h3:    target_hdb = -8'sd28;
            3'h4:    target_hdb = -8'sd34;
            3'h5:    target_hdb = -8'sd40;
            3'h6:    target_hdb = -8'sd44;
            default: target_hdb = -8'sd48;
        endcase
    endfunction : target_hdb

    function automatic logic signed [8:0] noise_hdb(input logic [4:0] c);
        // -(28 + 2N) dB, i.e. -(56 + 4N) half-dB
        noise_hdb = -(9'sd56 + $signed({2'b00, c, 2'b00}));
    endfunction : noise_hdb

    logic [2:0] hyst_sel;
    logic [4:0] noise_sel;
    assign hyst_sel  = {1'b0, ctl_second[`HYST_HI:`HYST_LO]};
    assign noise_sel = ctl_second[`NOISE_HI:`NOISE_LO];

    // =====================================================================
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg <= '0;
        end else begin
            cfg.enable      <= ctl_first[`BIT_ENABLE];
            cfg.target_hdb  <= target_hdb(ctl_first[`TARGET_HI:`TARGET_LO]);
            cfg.hyst_on     <= (hyst_sel[1:0] != `HYST_CODE_OFF);
            cfg.hyst_hdb    <= (hyst_sel[1:0] == `HYST_CODE_OFF) ? 4'h0 : (4'h2 << hyst_sel[1:0]);
            cfg.noise_on    <= (noise_sel != `NOISE_CODE_OFF);
            cfg.noise_hdb   <= (noise_sel == `NOISE_CODE_OFF) ? 9'sd0 : noise_hdb(noise_sel);
            cfg.clip_step   <= ctl_second[`BIT_CLIP_STEP];
            // unused codes are clamped so a bad write cannot push past 40 dB
            cfg.ceiling_hdb <= (ceiling > `CEIL_CODE_MAX) ? `CEIL_CODE_MAX : ceiling;
        end
    end
endmodule : agc_level_decode
`default_nettype wire

/* agc_config_status_regs_chk.sv */
// concurrent checks on the ports of the gain-control register slice
// assumes it is bound onto agc_config_status_regs, one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none
module agc_config_status_regs_chk #(
    parameter int TIME_W = 24
) (
    input wire logic                      mclk,
    input wire logic                      rst_n,
    input wire agc_regs_pkg::reg_req_t    reg_req,
    input wire logic [7:0]                reg_rdata,
    input wire logic                      reg_rvalid,
    input wire logic signed [7:0]         left_gain_in,
    input wire logic                      left_gain_upd,
    input wire agc_regs_pkg::level_cfg_t  right_cfg,
    input wire logic [TIME_W-1:0]         right_attack_periods,
    input wire logic [TIME_W-1:0]         right_decay_periods
);
    import agc_regs_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==============================================
    // status report
    AST_STATUS_RANGE: assert property (reg_req.rd && reg_req.addr == 8'h5D |=>
        reg_rvalid && (reg_rdata <= 8'h50 || reg_rdata >= 8'hE8)) else $error("status out of range");
    AST_STATUS_FOLLOW: assert property (left_gain_upd && left_gain_in >= -24 && left_gain_in <= 80
        ##1 !left_gain_upd ##1 reg_req.rd && reg_req.addr == 8'h5D && !left_gain_upd
        |=> reg_rdata == $past(left_gain_in, 3))
        else $error("status does not follow loop gain");
    // ==============================================
    // right configuration
    AST_ENABLE: assert property (reg_req.wr && reg_req.addr == 8'h5E ##1 !(reg_req.wr && reg_req.addr == 8'h5E)
        |=> right_cfg.enable == $past(reg_req.wdata[7], 2)) else $error("enable not taken");
    AST_CLIP: assert property (reg_req.wr && reg_req.addr == 8'h5F ##1 !(reg_req.wr && reg_req.addr == 8'h5F)
        |=> right_cfg.clip_step == $past(reg_req.wdata[0], 2)) else $error("clip stepping not taken");
    AST_HYST_OFF: assert property (reg_req.wr && reg_req.addr == 8'h5F && reg_req.wdata[7:6] == 2'h3
        ##1 !(reg_req.wr && reg_req.addr == 8'h5F) |=> !right_cfg.hyst_on && right_cfg.hyst_hdb == 4'h0)
        else $error("hysteresis not off");
    AST_NOISE: assert property (right_cfg.noise_on |->
        right_cfg.noise_hdb <= -60 && right_cfg.noise_hdb >= -180) else $error("noise threshold out of range");
    AST_CEIL: assert property (right_cfg.ceiling_hdb <= 7'h50) else $error("ceiling above 40 dB");
    AST_RSVD_FIRST: assert property (reg_req.rd && reg_req.addr == 8'h5E |=>
        reg_rdata[3:0] == 4'h0) else $error("reserved bits not zero");
    AST_RSVD_CEIL: assert property (reg_req.rd && reg_req.addr == 8'h60 |=>
        !reg_rdata[7]) else $error("reserved ceiling bit not zero");
    // decoded times lag reset release by one edge
    AST_ATTACK: assert property ($past(rst_n) |-> right_attack_periods[4:0] == 5'h00
        && right_attack_periods != '0) else $error("attack not a multiple of 32");
    AST_DECAY: assert property ($past(rst_n) |-> right_decay_periods[8:0] == 9'h000
        && right_decay_periods != '0) else $error("decay not a multiple of 512");
endmodule : agc_config_status_regs_chk
bind agc_config_status_regs agc_config_status_regs_chk #(.TIME_W(TIME_W)) i_agc_config_status_regs_chk (
    .mclk(mclk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .left_gain_in(left_gain_in), .left_gain_upd(left_gain_upd), .right_cfg(right_cfg),
    .right_attack_periods(right_attack_periods), .right_decay_periods(right_decay_periods));
`default_nettype wire

/* tb_agc_config_status_regs.sv */
// self-checking bench of the gain-control register slice
// assumes the checker file is compiled alongside; inputs change on falling edges
`timescale 1ns/100ps
`default_nettype none
module tb_agc_config_status_regs;
    import agc_regs_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    reg_req_t          req = '0;
    logic signed [7:0] gin = 8'h00;
    logic              upd = 1'b0;
    logic [7:0]        reg_rdata;
    logic              reg_rvalid;
    level_cfg_t        cfg;
    logic [23:0]       atk;
    logic [23:0]       dec;
    int                errors = 0;
    int                num_checks = 0;
    row_t rows[8] = '{'{8'h5D, 8'h33, 8'h00}, '{8'h5E, 8'hFF, 8'hF0}, '{8'h5F, 8'hC1, 8'hC1},
        '{8'h5F, 8'h3E, 8'h3E}, '{8'h60, 8'hD0, 8'h50}, '{8'h61, 8'hFF, 8'hFF},
        '{8'h62, 8'h5A, 8'h5A}, '{8'h70, 8'hAA, 8'h00}};
    row_t gains[7] = '{'{0, 8'h10, 8'h10}, '{0, 8'hE8, 8'hE8}, '{0, 8'h50, 8'h50}, '{0, 8'h7F, 8'h50},
        '{0, 8'h80, 8'hE8}, '{0, 8'hE7, 8'hE8}, '{0, 8'hFF, 8'hFF}};
    logic [7:0] rst_exp[6] = '{8'h00, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h00};
    logic [7:0] tgt[8] = '{8'hF5, 8'hEC, 8'hE8, 8'hE4, 8'hDE, 8'hD8, 8'hD4, 8'hD0};
    logic [3:0] hys[4] = '{4'h2, 4'h4, 4'h8, 4'h0};
    agc_config_status_regs i_agc_config_status_regs (.mclk(mclk), .rst_n(rst_n), .reg_req(req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .left_gain_in(gin), .left_gain_upd(upd),
        .right_cfg(cfg), .right_attack_periods(atk), .right_decay_periods(dec));
    always #4 mclk = ~mclk;
    // ==============================================
    // tasks
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk);
        req.wr = 1'b0;
    endtask : wr
    task automatic wr_settle(input logic [7:0] a, input logic [7:0] d);
        wr(a, d);
        repeat (2) @(negedge mclk);
    endtask : wr_settle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge mclk);
        req.rd = 1'b0;
        chk({15'h0, reg_rvalid, reg_rdata}, {16'h1, e});
    endtask : rd_chk
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // ==============================================
    // sequence
    initial begin
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++) rd_chk(8'h5D + 8'(i), rst_exp[i]);
        chk(atk, 24'h20);
        chk(dec, 24'h200);
        chk(24'({cfg.enable, cfg.clip_step}), 24'h0);
        for (int i = 0; i < 8; i++) begin
            wr(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        chk(atk, 24'h3F000);
        chk(dec, 24'hB800);
        chk(24'(cfg.ceiling_hdb), 24'h50);
        chk(24'({cfg.noise_on, cfg.noise_hdb}), 24'h34C);
        for (int c = 0; c < 8; c++) begin
            wr_settle(8'h5E, {1'b1, 3'(c), 4'h0});
            chk(24'({cfg.enable, cfg.target_hdb}), {15'h0, 1'b1, tgt[c]});
        end
        for (int c = 0; c < 4; c++) begin
            wr_settle(8'h5F, {2'(c), 6'h01});
            chk(24'({cfg.hyst_on, cfg.hyst_hdb, cfg.noise_on, cfg.clip_step}), {17'h0, c != 3, hys[c], 2'h1});
        end
        wr_settle(8'h5F, 8'h02);
        chk(24'({cfg.noise_on, cfg.clip_step, cfg.noise_hdb}), 24'h5C4);
        wr_settle(8'h61, 8'h07);
        chk(atk, 24'h1000);
        // out-of-range loop gains must clamp to the documented report range
        for (int i = 0; i < 7; i++) begin
            @(negedge mclk);
            upd = 1'b1;
            gin = gains[i].d;
            @(negedge mclk);
            upd = 1'b0;
            rd_chk(8'h5D, gains[i].e);
        end
        wr(8'h5D, 8'h00);
        rd_chk(8'h5D, 8'hFF);
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        rd_chk(8'h5D, 8'h00);
        rd_chk(8'h60, 8'h7F);
        rd_chk(8'h5E, 8'h00);
        report_and_stop();
    end
    initial begin
        #20000;
        errors++;
        report_and_stop();
    end
endmodule : tb_agc_config_status_regs
`default_nettype wire
